// ### pkg/vsync_serial_pkg.sv
`default_nettype none
package vsync_serial_pkg;
   localparam logic [4:0] mode_addr = 5'h00;
   localparam logic [4:0] ctrl_addr = 5'h04;
   localparam logic [4:0] txbuf_addr = 5'h08;
   localparam logic [4:0] rxbuf_addr = 5'h0c;
   localparam logic [4:0] ch0_addr = 5'h10;
   localparam logic [4:0] ch2_addr = 5'h14;
   localparam int char_w = 8;
   localparam int len_lsb = 8;
   localparam int err_bit = 8;
   localparam logic [15:0] cmp_reset = 16'h0001;
   localparam logic [15:0] ch2_reset = 16'h0000;
   localparam logic [1:0] sync_mode = 2'h1;
   typedef logic [3:0] len_t;
   typedef struct packed {
      logic [1:0] iface_mode;
      logic tx_irq_source_select;
      logic bit_order_select;
      logic clock_source_select;
   } mode_s;
   localparam mode_s mode_reset = '{2'h0, 1'b0, 1'b0, 1'b0};
   typedef struct packed {
      logic in_polarity_invert;
      logic out_polarity_invert;
      logic rx_enable;
      logic tx_enable;
   } ctrl_s;
   localparam ctrl_s ctrl_reset = '{1'b0, 1'b0, 1'b0, 1'b0};
endpackage : vsync_serial_pkg
`default_nettype wire

// ### rtl/variable_sync_serial_port.sv
`timescale 1ns/1ns
`default_nettype none
module variable_sync_serial_port
   import vsync_serial_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe,
   output logic serial_data_out_pin,
   input wire logic serial_data_in_pin,
   output logic tx_irq_request,
   output logic rx_irq_request
);
   mode_s mode_reg;
   ctrl_s ctrl_reg;
   logic [15:0] ch0_reg;
   logic [15:0] ch2_reg;
   logic [char_w-1:0] tx_data_reg;
   len_t tx_len_reg;
   logic [char_w-1:0] rx_data_reg;
   logic rx_err_reg;
   logic tbe_reg;
   logic rxc_reg;
   logic ack_reg;
   logic [31:0] rd_reg;
   logic busy_reg;
   logic rx_on_reg;
   logic [char_w-1:0] sh_data_reg;
   len_t sh_len_reg;
   len_t idx_reg;
   logic [char_w-1:0] rx_sh_reg;
   logic [16:0] div_reg;
   logic iclk_reg;
   logic [2:0] eclk_sync_reg;
   logic [1:0] din_sync_reg;
   logic dout_reg;
   logic msb_reg;
   logic acc;
   logic wr_go;
   logic rd_go;
   logic fall;
   logic rise;
   logic start;
   logic done;
   logic din;
   logic ext_rise;
   logic ext_fall;
   logic int_tick;

   // bit at position idx of a len-bit character in the chosen order
   function automatic logic pick_bit(input logic [char_w-1:0] d,
                                     input len_t len, input len_t idx,
                                     input logic msb);
      len_t p;
      p = msb ? len_t'(len - idx - 4'h1) : idx;
      return d[p[2:0]];
   endfunction : pick_bit

   // length field 0 is read as a full 8-bit character
   function automatic len_t norm_len(input logic [3:0] f);
      return (f == 4'h0 || f > 4'h8) ? len_t'(char_w) : f;
   endfunction : norm_len

   // bus: one wait cycle, answer on the second edge
   assign acc = (read | write) & ~ack_reg;
   assign waitrequest = acc;
   assign wr_go = write & ack_reg;
   assign rd_go = read & ack_reg;
   assign readdata = rd_reg;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= acc;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rd_reg <= 32'h0;
      end else if (read & ~ack_reg) begin
         unique case (address)
            mode_addr: rd_reg <= {27'h0, mode_reg};
            ctrl_addr: rd_reg <= {25'h0, ctrl_reg[3:2], rxc_reg,
                                  ctrl_reg[1], tbe_reg, ~busy_reg,
                                  ctrl_reg[0]};
            txbuf_addr: rd_reg <= {20'h0, tx_len_reg, tx_data_reg};
            rxbuf_addr: rd_reg <= {23'h0, rx_err_reg, rx_data_reg};
            ch0_addr: rd_reg <= {16'h0, ch0_reg};
            ch2_addr: rd_reg <= {16'h0, ch2_reg};
            default: rd_reg <= 32'h0;
         endcase
      end
   end

   // configuration registers written by software
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         mode_reg <= mode_reset;
         ctrl_reg <= ctrl_reset;
         ch0_reg <= cmp_reset;
         ch2_reg <= ch2_reset;
      end else if (wr_go) begin
         if (address == mode_addr) begin
            mode_reg <= writedata[4:0];
         end
         if (address == ctrl_addr) begin
            ctrl_reg <= {writedata[6:5], writedata[3], writedata[0]};
         end
         if (address == ch0_addr) begin
            ch0_reg <= writedata[15:0];
         end
         if (address == ch2_addr) begin
            ch2_reg <= writedata[15:0];
         end
      end
   end

   // transmit buffer holds data and length
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         tx_data_reg <= 8'h00;
         tx_len_reg <= 4'h8;
      end else if (wr_go && address == txbuf_addr) begin
         tx_data_reg <= writedata[char_w-1:0];
         tx_len_reg <= norm_len(writedata[len_lsb+3:len_lsb]);
      end
   end

   // buffer empty flag; a write after a load refills it
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         tbe_reg <= 1'b1;
      end else if (wr_go && address == txbuf_addr) begin
         tbe_reg <= 1'b0;
      end else if (start) begin
         tbe_reg <= 1'b1;
      end
   end

   assign start = ctrl_reg.tx_enable & ~tbe_reg & ~busy_reg;

   // pin inputs pass two flops; edges use stages two and three
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         eclk_sync_reg <= 3'h7;
         din_sync_reg <= 2'h0;
      end else begin
         eclk_sync_reg <= {eclk_sync_reg[1:0], serial_clock_pin_i};
         din_sync_reg <= {din_sync_reg[0], serial_data_in_pin};
      end
   end
   assign ext_rise = eclk_sync_reg[1] & ~eclk_sync_reg[2];
   assign ext_fall = ~eclk_sync_reg[1] & eclk_sync_reg[2];
   assign din = din_sync_reg[1] ^ ctrl_reg.in_polarity_invert;

   // half period of n+2 base clocks
   // 17 bits, so the largest compare value does not wrap to a short period
   assign int_tick = busy_reg && div_reg == {1'b0, ch0_reg} + 17'h1;

   // channel 0 waveform: idles high, first toggle goes low
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         div_reg <= 17'h0;
         iclk_reg <= 1'b1;
      end else if (!busy_reg || done) begin
         div_reg <= 17'h0;
         iclk_reg <= 1'b1;
      end else if (int_tick) begin
         div_reg <= 17'h0;
         iclk_reg <= ~iclk_reg;
      end else begin
         div_reg <= div_reg + 17'h1;
      end
   end

   // external clock edges replace the internal ones
   assign fall = mode_reg.clock_source_select ? ext_fall
                 : int_tick & iclk_reg;
   assign rise = mode_reg.clock_source_select ? ext_rise
                 : int_tick & ~iclk_reg;
   // character ends after len rising edges
   assign done = busy_reg & rise & (idx_reg + 4'h1 == sh_len_reg);

   assign serial_clock_pin_o = iclk_reg;
   assign serial_clock_pin_oe = ~mode_reg.clock_source_select;

   // shifter: first bit driven on load, next bits after falling edges
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         busy_reg <= 1'b0;
         rx_on_reg <= 1'b0;
         sh_data_reg <= 8'h00;
         sh_len_reg <= 4'h8;
         idx_reg <= 4'h0;
         msb_reg <= 1'b0;
         dout_reg <= 1'b1;
      end else if (start) begin
         busy_reg <= 1'b1;
         // receive joins only a started transmit
         rx_on_reg <= ctrl_reg.rx_enable;
         sh_data_reg <= tx_data_reg;
         sh_len_reg <= tx_len_reg;
         idx_reg <= 4'h0;
         msb_reg <= mode_reg.bit_order_select;
         dout_reg <= pick_bit(tx_data_reg, tx_len_reg, 4'h0,
                              mode_reg.bit_order_select);
      end else if (done) begin
         busy_reg <= 1'b0;
         rx_on_reg <= 1'b0;
         dout_reg <= 1'b1;
      end else if (busy_reg && rise) begin
         idx_reg <= idx_reg + 4'h1;
      end else if (busy_reg && fall && idx_reg != 4'h0) begin
         dout_reg <= pick_bit(sh_data_reg, sh_len_reg, idx_reg, msb_reg);
      end
   end
   assign serial_data_out_pin = dout_reg ^ ctrl_reg.out_polarity_invert;

   // receive shifter samples on rising edges
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rx_sh_reg <= 8'h00;
      end else if (start) begin
         rx_sh_reg <= 8'h00;
      end else if (busy_reg && rise) begin
         if (msb_reg) begin
            rx_sh_reg <= {rx_sh_reg[6:0], din};
         end else begin
            rx_sh_reg <= {din, rx_sh_reg[7:1]};
         end
      end
   end

   // move to receive buffer; lsb-first is right aligned
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rx_data_reg <= 8'h00;
      end else if (done && rx_on_reg) begin
         if (msb_reg) begin
            rx_data_reg <= {rx_sh_reg[6:0], din};
         end else begin
            rx_data_reg <= 8'({din, rx_sh_reg[7:1]}
                              >> (4'h8 - sh_len_reg));
         end
      end
   end

   // overrun; buffer still overwritten, so undefined
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rx_err_reg <= 1'b0;
      end else if (done && rx_on_reg) begin
         rx_err_reg <= rxc_reg & ~(rd_go && address == rxbuf_addr);
      end
   end

   // receive complete: set wins over the clearing read
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rxc_reg <= 1'b0;
      end else if (done && rx_on_reg) begin
         rxc_reg <= 1'b1;
      end else if (rd_go && address == rxbuf_addr) begin
         rxc_reg <= 1'b0;
      end
   end

   // request pulses to the interrupt controller
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         tx_irq_request <= 1'b0;
         rx_irq_request <= 1'b0;
      end else begin
         tx_irq_request <= mode_reg.tx_irq_source_select ? done : start;
         rx_irq_request <= done & rx_on_reg;
      end
   end
endmodule : variable_sync_serial_port
`default_nettype wire

// ### verif/vsync_checker.sv
`timescale 1ns/1ns
`default_nettype none
module vsync_checker
   import vsync_serial_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [4:0] address,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic waitrequest,
   input wire logic serial_clock_pin_o,
   input wire logic serial_clock_pin_oe,
   input wire logic tx_irq_request,
   input wire logic rx_irq_request
);
   logic [15:0] ch0;
   logic [16:0] low_n;
   logic src, te, re, acc, ck, oe, ti, ri;
   assign acc = write && !waitrequest;
   assign {ck, oe} = {serial_clock_pin_o, serial_clock_pin_oe};
   assign {ti, ri} = {tx_irq_request, rx_irq_request};
   // shadows taken at the accept edge only
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ch0 <= cmp_reset;
         {src, te, re} <= 3'h0;
      end else if (acc && address == ch0_addr) begin
         ch0 <= writedata[15:0];
      end else if (acc && address == mode_addr) begin
         src <= writedata[2];
      end else if (acc && address == ctrl_addr) begin
         {re, te} <= {writedata[3], writedata[0]};
      end
   end
   // counts low cycles; the high phase is not checked since idle is high
   always_ff @(posedge core_clk) begin
      low_n <= (!nrst || ck) ? 17'h0 : low_n + 17'h1;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence s_drop(s);
      ##1 !s;
   endsequence
   AST_OE_MODE: assert property (
      acc && address == mode_addr |=> oe == !$past(writedata[0]))
      else $error("clock drive does not follow source");
   AST_CLK_HALF: assert property (
      $rose(ck) && oe |-> low_n == {1'b0, ch0} + 17'h2)
      else $error("shift clock low time wrong");
   AST_TX_PULSE: assert property (ti |-> s_drop(ti))
      else $error("tx request not a pulse");
   AST_RX_PULSE: assert property (ri |-> s_drop(ri))
      else $error("rx request not a pulse");
   AST_TX_SRC1: assert property (src && re && ti |-> ri)
      else $error("tx request not at completion");
   AST_TX_SRC0: assert property (!src && oe && ti |-> ck && !ri)
      else $error("tx request not at start");
   AST_TX_TE: assert property (ti |-> te)
      else $error("transfer without tx enable");
   AST_RX_RE: assert property (ri |-> re && te)
      else $error("receive without enables");
endmodule : vsync_checker
bind variable_sync_serial_port vsync_checker vsync_checker_i (
   .core_clk(core_clk), .nrst(nrst), .address(address), .write(write),
   .writedata(writedata), .waitrequest(waitrequest),
   .serial_clock_pin_o(serial_clock_pin_o),
   .serial_clock_pin_oe(serial_clock_pin_oe),
   .tx_irq_request(tx_irq_request), .rx_irq_request(rx_irq_request));
`default_nettype wire

// ### verif/sync_peer.sv
`timescale 1ns/1ns
`default_nettype none
module sync_peer (
   input wire logic core_clk,
   input wire logic sclk,
   input wire logic dout,
   input wire logic ld,
   input wire logic [7:0] pv,
   input wire logic go,
   output logic din,
   output logic psclk,
   output logic [7:0] cap
);
   logic [7:0] pat;
   logic [4:0] nh = 5'h0;
   logic [3:0] hc = 4'h0;
   logic sq = 1'b1;
   logic dq = 1'b1;
   initial begin
      {psclk, din, pat, cap} = {2'b11, 16'h0};
   end
   // own clock, 24-cycle period, still between frames
   always @(posedge core_clk) begin
      if (go) begin
         nh <= 5'h10;
      end else if (nh != 5'h0) begin
         hc <= (hc == 4'hb) ? 4'h0 : hc + 4'h1;
         if (hc == 4'hb) begin
            nh <= nh - 5'h1;
            psclk <= ~psclk;
         end
      end
   end
   // clock edges seen one cycle late; dq keeps data from before the edge,
   // since the device may move its data on that very edge
   always @(posedge core_clk) begin
      sq <= sclk;
      dq <= dout;
      if (ld) begin
         pat <= pv;
      end else if (sq && !sclk) begin
         // bit i leaves after falling edge i; order is the device's job
         din <= pat[0];
         pat <= {~pat[0], pat[7:1]};
      end
      if (!sq && sclk) begin
         cap <= {cap[6:0], dq};
      end
   end
endmodule : sync_peer
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
   import vsync_serial_pkg::*;
;
   logic core_clk, nrst, read, write, waitrequest, ld, go, psclk, unread;
   logic serial_clock_pin_o, serial_clock_pin_oe, serial_data_out_pin;
   logic serial_data_in_pin, tx_irq_request, rx_irq_request;
   logic [4:0] address;
   logic [31:0] writedata, readdata, q, ntx, nrx;
   logic [7:0] pv, cap;
   int n_mismatch, comparisons;
   wire logic serial_clock_pin_i = serial_clock_pin_oe ? serial_clock_pin_o
      : psclk;
   variable_sync_serial_port variable_sync_serial_port_i (
      .core_clk(core_clk), .nrst(nrst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .serial_clock_pin_i(serial_clock_pin_i),
      .serial_clock_pin_o(serial_clock_pin_o),
      .serial_clock_pin_oe(serial_clock_pin_oe),
      .serial_data_out_pin(serial_data_out_pin),
      .serial_data_in_pin(serial_data_in_pin),
      .tx_irq_request(tx_irq_request), .rx_irq_request(rx_irq_request));
   sync_peer sync_peer_i (.core_clk(core_clk), .sclk(serial_clock_pin_i),
      .dout(serial_data_out_pin), .ld(ld), .pv(pv), .go(go),
      .din(serial_data_in_pin), .psclk(psclk), .cap(cap));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      ntx <= ntx + {31'h0, tx_irq_request === 1'b1};
      nrx <= nrx + {31'h0, rx_irq_request === 1'b1};
   end
   function automatic logic [7:0] ord(input logic [7:0] v, input int l,
         input logic msb);
      ord = 8'h00;
      for (int i = 0; i < l; i++) begin
         ord[msb ? l - 1 - i : i] = v[i];
      end
   endfunction : ord
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [4:0] a,
         input logic [31:0] d, output logic [31:0] o);
      {address, writedata, write, read} <= {a, d, w, !w};
      @(posedge core_clk);
      while (waitrequest !== 1'b0) begin
         @(posedge core_clk);
      end
      o = readdata;
      {write, read} <= 2'b00;
      @(posedge core_clk);
   endtask : bus
   task automatic fr(input logic [2:0] m, input logic [6:0] c,
         input logic [11:0] t, input logic [7:0] p, input logic x, rd);
      int l;
      logic [31:0] k, kr;
      logic [7:0] e;
      l = (t[11:8] == 4'h0 || t[11:8] > 4'h8) ? 8 : int'(t[11:8]);
      {k, kr} = {ntx, nrx};
      // timer setup is not modelled; base clock is core_clk
      bus(1'b1, mode_addr, {27'h0, sync_mode, m}, q);
      bus(1'b1, ctrl_addr, {25'h0, c}, q);
      {ld, pv} <= {1'b1, p};
      @(posedge core_clk);
      ld <= 1'b0;
      bus(1'b1, txbuf_addr, {20'h0, t}, q);
      go <= x;
      @(posedge core_clk);
      go <= 1'b0;
      wait (nrx != kr);
      @(posedge core_clk);
      bus(1'b0, ctrl_addr, 32'h0, q);
      chk("ctrl", {25'h0, c} | 32'h16, q);
      chk("tx irqs", k + 32'h1, ntx);
      e = ord(t[7:0] ^ {8{c[5]}}, l, !m[1]) & ord(8'hff, l, 1'b0);
      chk("peer", {24'h0, e}, {24'h0, cap & ord(8'hff, l, 1'b0)});
      if (rd) begin
         bus(1'b0, rxbuf_addr, 32'h0, q);
         if (unread) chk("error", 32'h1, {31'h0, q[8]});
         else chk("rx", {24'h0, ord(p ^ {8{c[6]}}, l, m[1])}, q);
      end
      unread = !rd;
   endtask : fr
   task automatic final_report();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   initial begin
      {nrst, read, write, ld, go, unread, pv, address} = 19'h0;
      {writedata, ntx, nrx} = 96'h0;
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      bus(1'b0, ctrl_addr, 32'h0, q);
      chk("ctrl", 32'h6, q);
      bus(1'b0, 5'h1c, 32'h0, q);
      chk("unmapped", 32'h0, q);
      bus(1'b1, ch0_addr, 32'h8, q);
      bus(1'b0, ch0_addr, 32'h0, q);
      chk("ch0", 32'h8, q);
      bus(1'b1, ch2_addr, 32'h3, q);
      bus(1'b0, ch2_addr, 32'h0, q);
      chk("ch2", 32'h3, q);
      bus(1'b1, txbuf_addr, 32'h835, q);
      repeat (6) begin
         bus(1'b0, ctrl_addr, 32'h0, q);
         chk("held", 32'h2, q);
      end
      bus(1'b1, ctrl_addr, 32'h1, q);
      do bus(1'b0, ctrl_addr, 32'h0, q); while (q[2:1] !== 2'b11);
      chk("ctrl", 32'h7, q);
      chk("rx irqs", 32'h0, nrx);
      chk("peer", {24'h0, ord(8'h35, 8, 1'b1)}, {24'h0, cap});
      fr(3'h0, 7'h09, 12'h035, 8'ha5, 1'b0, 1'b1);
      fr(3'h6, 7'h69, 12'h513, 8'h0b, 1'b0, 1'b1);
      fr(3'h0, 7'h09, 12'h101, 8'h00, 1'b0, 1'b1);
      fr(3'h1, 7'h09, 12'hcc6, 8'h5a, 1'b1, 1'b0);
      fr(3'h1, 7'h09, 12'h8f0, 8'h3c, 1'b1, 1'b1);
      fr(3'h0, 7'h09, 12'h42a, 8'h09, 1'b0, 1'b1);
      final_report();
   end
   initial begin
      repeat (8000) @(posedge core_clk);
      n_mismatch++;
      final_report();
   end
endmodule : testbench
`default_nettype wire
